// file: hdl/ptvd_top.sv
// PCI-to-VMEbus target images 6 and 7: registers, decode and mapping.
// Assumes a synchronous register master and a one-cycle PCI request.
`timescale 1ns/1ps
`include "ptvd_regs.svh"

module ptvd_top (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic pci_req,
    input wire logic [31:0] pci_addr,
    input wire logic pci_io,
    input wire logic pci_write,
    output logic vme_req,
    output logic vme_image,
    output logic [31:0] vme_addr,
    output logic [5:0] vme_am,
    output logic [1:0] vme_width,
    output logic [2:0] vme_space,
    output logic vme_blt,
    output logic vme_mblt,
    output logic vme_posted,
    output logic pci_miss
);
    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Index {image, kind}: kind 0 ctl, 1 base, 2 bound, 3 offset
    function automatic logic [3:0] reg_sel(input logic [11:0] a);
        logic [3:0] s;
        s = 4'hf;
        unique case (a)
            `PTVD_OFS_CTL6: s = 4'h0;
            `PTVD_OFS_BS6: s = 4'h1;
            `PTVD_OFS_BD6: s = 4'h2;
            `PTVD_OFS_TO6: s = 4'h3;
            `PTVD_OFS_CTL7: s = 4'h4;
            `PTVD_OFS_BS7: s = 4'h5;
            `PTVD_OFS_BD7: s = 4'h6;
            `PTVD_OFS_TO7: s = 4'h7;
            `PTVD_OFS_STAT: s = 4'h8;
            default: s = 4'hf;
        endcase
        return s;
    endfunction : reg_sel

    logic [31:0] ctl_q [2];
    logic [31:0] bs_q [2];
    logic [31:0] bd_q [2];
    logic [31:0] to_q [2];
    logic [2:0] stat_q;
    logic [2:0] stat_set;
    logic [3:0] wr_sel;

    assign wr_sel = reg_sel(reg_addr);

    // ------------------------------------------------------------
    // Window registers
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_img_regs
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                ctl_q[i] <= `PTVD_CTL_RST;
            end else if (reg_wr && wr_sel == {1'b0, 1'(i), 2'd0}) begin
                ctl_q[i] <= reg_wdata & `PTVD_CTL_MASK;
            end
        end

        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                bs_q[i] <= `PTVD_WIN_RST;
                bd_q[i] <= `PTVD_WIN_RST;
                to_q[i] <= `PTVD_WIN_RST;
            end else if (reg_wr) begin
                if (wr_sel == {1'b0, 1'(i), 2'd1}) begin
                    bs_q[i] <= reg_wdata & `PTVD_WIN_MASK;
                end
                if (wr_sel == {1'b0, 1'(i), 2'd2}) begin
                    bd_q[i] <= reg_wdata & `PTVD_WIN_MASK;
                end
                if (wr_sel == {1'b0, 1'(i), 2'd3}) begin
                    to_q[i] <= reg_wdata & `PTVD_WIN_MASK;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Decode status, write one to clear
    // ------------------------------------------------------------
    // A new event in the clearing cycle keeps its bit set
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= 3'b000;
        end else if (reg_wr && wr_sel == 4'h8) begin
            stat_q <= (stat_q & ~reg_wdata[2:0]) | stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    // ------------------------------------------------------------
    // Register read, data valid the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            unique case (reg_sel(reg_addr))
                4'h0: reg_rdata <= ctl_q[0];
                4'h1: reg_rdata <= bs_q[0];
                4'h2: reg_rdata <= bd_q[0];
                4'h3: reg_rdata <= to_q[0];
                4'h4: reg_rdata <= ctl_q[1];
                4'h5: reg_rdata <= bs_q[1];
                4'h6: reg_rdata <= bd_q[1];
                4'h7: reg_rdata <= to_q[1];
                4'h8: reg_rdata <= {29'h0000_0000, stat_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Image decoders
    // ------------------------------------------------------------
    logic [1:0] img_hit;
    logic [31:0] img_addr [2];
    logic [5:0] img_am [2];
    logic [1:0] img_blt;
    logic [1:0] img_mblt;
    logic [1:0] img_posted;

    for (genvar i = 0; i < 2; i++) begin : g_img
        ptvd_image u_image (
            .ctl(ctl_q[i]),
            .window_base(bs_q[i]),
            .window_bound(bd_q[i]),
            .address_translation_offset(to_q[i]),
            .pci_addr(pci_addr),
            .pci_io(pci_io),
            .pci_write(pci_write),
            .hit(img_hit[i]),
            .vme_addr(img_addr[i]),
            .vme_am(img_am[i]),
            .blt(img_blt[i]),
            .mblt(img_mblt[i]),
            .posted(img_posted[i])
        );
    end

    // Image 6 wins where the two windows overlap
    logic sel_d;
    assign sel_d = !img_hit[0];
    assign stat_set = {pci_req && img_hit == 2'b00,
        pci_req && img_hit == 2'b10, pci_req && img_hit[0]};

    // ------------------------------------------------------------
    // Mapped VMEbus request
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            vme_req <= 1'b0;
            pci_miss <= 1'b0;
        end else begin
            vme_req <= pci_req && img_hit != 2'b00;
            pci_miss <= pci_req && img_hit == 2'b00;
        end
    end

    // Attributes hold their last value between requests
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            vme_image <= 1'b0;
            vme_addr <= 32'h0000_0000;
            vme_am <= 6'h00;
            vme_width <= 2'b00;
            vme_space <= 3'b000;
            vme_blt <= 1'b0;
            vme_mblt <= 1'b0;
            vme_posted <= 1'b0;
        end else if (pci_req && img_hit != 2'b00) begin
            vme_image <= sel_d;
            vme_addr <= img_addr[sel_d];
            vme_am <= img_am[sel_d];
            vme_width <= ctl_q[sel_d][`PTVD_VDW_HI:`PTVD_VDW_LO];
            vme_space <= ctl_q[sel_d][`PTVD_VAS_HI:`PTVD_VAS_LO];
            vme_blt <= img_blt[sel_d];
            vme_mblt <= img_mblt[sel_d];
            vme_posted <= img_posted[sel_d];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [31:0] chk_ctl;
    logic [31:0] chk_bs;
    logic [31:0] chk_bd;
    logic [31:0] chk_to;
    logic [127:0] prev_q [2];

    // Image settings one cycle back, as the request edge saw them
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q[0] <= {`PTVD_CTL_RST, `PTVD_WIN_RST, `PTVD_WIN_RST,
                `PTVD_WIN_RST};
            prev_q[1] <= {`PTVD_CTL_RST, `PTVD_WIN_RST, `PTVD_WIN_RST,
                `PTVD_WIN_RST};
        end else begin
            prev_q[0] <= {ctl_q[0], bs_q[0], bd_q[0], to_q[0]};
            prev_q[1] <= {ctl_q[1], bs_q[1], bd_q[1], to_q[1]};
        end
    end

    assign {chk_ctl, chk_bs, chk_bd, chk_to} = prev_q[vme_image];

    width_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req |-> vme_width == chk_ctl[`PTVD_VDW_HI:`PTVD_VDW_LO]
    ) else $error("data width not from image control");

    space_legal_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req |-> vme_space != ptvd_pkg::SPACE_RSV3 &&
            vme_space != ptvd_pkg::SPACE_RSV4
    ) else $error("reserved space decoded");

    am_space_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req && vme_space == ptvd_pkg::SPACE_CRCSR |-> vme_am == 6'h2f
    ) else $error("CR/CSR modifier wrong");

    blt_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req |-> vme_blt == (chk_ctl[`PTVD_VCT_BIT] &&
            (vme_space == ptvd_pkg::SPACE_A24 ||
            vme_space == ptvd_pkg::SPACE_A32) &&
            vme_width != ptvd_pkg::WIDTH_64)
    ) else $error("block transfer select misapplied");

    blt_width_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req && vme_width == ptvd_pkg::WIDTH_64 |-> !vme_blt
    ) else $error("BLT at 64-bit width");

    mblt_use_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req && vme_width == ptvd_pkg::WIDTH_64 &&
            vme_space inside {ptvd_pkg::SPACE_A24, ptvd_pkg::SPACE_A32}
            |-> vme_mblt && vme_am[1:0] == 2'b00
    ) else $error("MBLT not used");

    pci_space_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req |-> $past(pci_io) == chk_ctl[`PTVD_LAS_BIT]
    ) else $error("PCI space select ignored");

    io_coupled_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pci_req && pci_io |=> !vme_posted || !vme_req
    ) else $error("I/O cycle posted");

    window_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req |-> $past(pci_addr[31:16]) >= chk_bs[31:16]
    ) else $error("hit below base");

    window_high_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req && chk_bd[31:16] != 16'h0000 |->
            $past(pci_addr[31:16]) < chk_bd[31:16]
    ) else $error("hit at or above bound");

    open_bound_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pci_req && ctl_q[0][`PTVD_EN_BIT] &&
            pci_io == ctl_q[0][`PTVD_LAS_BIT] &&
            !(ctl_q[0][`PTVD_VAS_HI:`PTVD_VAS_LO] inside
            {ptvd_pkg::SPACE_RSV3, ptvd_pkg::SPACE_RSV4}) &&
            bd_q[0] == 32'h0000_0000 && pci_addr[31:16] >= bs_q[0][31:16]
            |=> vme_req && !vme_image
    ) else $error("open window missed");

    granule_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bs_q[0][15:0] == 16'h0000 && bd_q[1][15:0] == 16'h0000
    ) else $error("window below 64 KB granule");

    xlat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req |-> vme_addr == {16'($past(pci_addr[31:16]) +
            chk_to[31:16]), $past(pci_addr[15:0])}
    ) else $error("translated address wrong");

    disabled_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pci_req && !ctl_q[0][`PTVD_EN_BIT] && !ctl_q[1][`PTVD_EN_BIT]
            |=> !vme_req && pci_miss
    ) else $error("disabled window decoded");

    posted_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req |-> vme_posted == ($past(pci_write) &&
            chk_ctl[`PTVD_POSTED_WRITE_SELECT_BIT] && !chk_ctl[`PTVD_LAS_BIT])
    ) else $error("posting choice wrong");

    am_priv_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vme_req && vme_space == ptvd_pkg::SPACE_A32 && !vme_blt &&
            !vme_mblt |-> vme_am == {3'b001,
            chk_ctl[`PTVD_SUPER_BIT], chk_ctl[`PTVD_PGM_BIT],
            !chk_ctl[`PTVD_PGM_BIT]}
    ) else $error("address modifier wrong");

endmodule : ptvd_top

// file: inc/ptvd_regs.svh
// Register map, field positions and reset values of the target images.
// Included by the design files; holds definitions only.
`ifndef PTVD_REGS_SVH
`define PTVD_REGS_SVH

// Byte offsets on the register port
`define PTVD_OFS_CTL6 12'h1c8
`define PTVD_OFS_BS6 12'h1cc
`define PTVD_OFS_BD6 12'h1d0
`define PTVD_OFS_TO6 12'h1d4
`define PTVD_OFS_CTL7 12'h1dc
`define PTVD_OFS_BS7 12'h1e0
`define PTVD_OFS_BD7 12'h1e4
`define PTVD_OFS_TO7 12'h1e8
`define PTVD_OFS_STAT 12'h1f0

// Control field positions
`define PTVD_EN_BIT 31
`define PTVD_POSTED_WRITE_SELECT_BIT 30
`define PTVD_VDW_HI 23
`define PTVD_VDW_LO 22
`define PTVD_VAS_HI 18
`define PTVD_VAS_LO 16
`define PTVD_PGM_BIT 14
`define PTVD_SUPER_BIT 12
`define PTVD_VCT_BIT 8
`define PTVD_LAS_BIT 0

// Reset values and writable masks
`define PTVD_CTL_RST 32'h0080_0000
`define PTVD_CTL_MASK 32'hc0c7_5101
`define PTVD_WIN_RST 32'h0000_0000
`define PTVD_WIN_MASK 32'hffff_0000
`define PTVD_STAT_MASK 32'h0000_0007

// Address modifier upper bits per space
`define PTVD_AM_A32 3'b001
`define PTVD_AM_A24 3'b111
`define PTVD_AM_SHORT 3'b101
`define PTVD_AM_USER 3'b010

`endif

// file: inc/ptvd_pkg.sv
// Types shared by the target image decoder files.
// Assumes ptvd_regs.svh supplies the numeric map.
package ptvd_pkg;

    typedef enum logic [1:0] {
        WIDTH_8 = 2'b00,
        WIDTH_16 = 2'b01,
        WIDTH_32 = 2'b10,
        WIDTH_64 = 2'b11
    } ptvd_width_type;

    typedef enum logic [2:0] {
        SPACE_A16 = 3'b000,
        SPACE_A24 = 3'b001,
        SPACE_A32 = 3'b010,
        SPACE_RSV3 = 3'b011,
        SPACE_RSV4 = 3'b100,
        SPACE_CRCSR = 3'b101,
        SPACE_USER1 = 3'b110,
        SPACE_USER2 = 3'b111
    } ptvd_space_type;

endpackage : ptvd_pkg

// file: hdl/ptvd_image.sv
// Window match, address translation and cycle attributes of one image.
// Purely combinational; the parent registers every result.
`timescale 1ns/1ps
`include "ptvd_regs.svh"

module ptvd_image (
    input wire logic [31:0] ctl,
    input wire logic [31:0] window_base,
    input wire logic [31:0] window_bound,
    input wire logic [31:0] address_translation_offset,
    input wire logic [31:0] pci_addr,
    input wire logic pci_io,
    input wire logic pci_write,
    output logic hit,
    output logic [31:0] vme_addr,
    output logic [5:0] vme_am,
    output logic blt,
    output logic mblt,
    output logic posted
);
    logic [2:0] vme_address_space;
    logic [1:0] vme_max_data_width;
    logic long_space;
    logic reserved_space;
    logic above_base;
    logic below_bound;
    logic [1:0] am_low;

    assign vme_address_space = ctl[`PTVD_VAS_HI:`PTVD_VAS_LO];
    assign vme_max_data_width = ctl[`PTVD_VDW_HI:`PTVD_VDW_LO];
    assign long_space = (vme_address_space == ptvd_pkg::SPACE_A24) ||
        (vme_address_space == ptvd_pkg::SPACE_A32);
    assign reserved_space = (vme_address_space == ptvd_pkg::SPACE_RSV3) ||
        (vme_address_space == ptvd_pkg::SPACE_RSV4);

    // Only bits 31:16 compare: 64 KB granules
    assign above_base = pci_addr[31:16] >= window_base[31:16];
    assign below_bound = (window_bound[31:16] == 16'h0000) ||
        (pci_addr[31:16] < window_bound[31:16]);
    assign hit = ctl[`PTVD_EN_BIT] &&
        (pci_io == ctl[`PTVD_LAS_BIT]) &&
        !reserved_space && above_base && below_bound;

    // Carry out of bit 31 is dropped: wraps modulo 4 GB
    assign vme_addr = {pci_addr[31:16] +
        address_translation_offset[31:16], pci_addr[15:0]};

    assign posted = ctl[`PTVD_POSTED_WRITE_SELECT_BIT] && !ctl[`PTVD_LAS_BIT] &&
        pci_write;
    assign mblt = long_space &&
        (vme_max_data_width == ptvd_pkg::WIDTH_64);
    assign blt = ctl[`PTVD_VCT_BIT] && long_space &&
        (vme_max_data_width != ptvd_pkg::WIDTH_64);

    always_comb begin
        if (mblt) begin
            am_low = 2'b00;
        end else if (blt) begin
            am_low = 2'b11;
        end else if (ctl[`PTVD_PGM_BIT]) begin
            am_low = 2'b10;
        end else begin
            am_low = 2'b01;
        end
    end

    always_comb begin
        unique case (vme_address_space)
            ptvd_pkg::SPACE_A32: begin
                vme_am = {`PTVD_AM_A32, ctl[`PTVD_SUPER_BIT], am_low};
            end
            ptvd_pkg::SPACE_A24: begin
                vme_am = {`PTVD_AM_A24, ctl[`PTVD_SUPER_BIT], am_low};
            end
            ptvd_pkg::SPACE_A16: begin
                vme_am = {`PTVD_AM_SHORT, ctl[`PTVD_SUPER_BIT], 2'b01};
            end
            ptvd_pkg::SPACE_CRCSR: begin
                vme_am = {`PTVD_AM_SHORT, 3'b111};
            end
            ptvd_pkg::SPACE_USER1, ptvd_pkg::SPACE_USER2: begin
                vme_am = {`PTVD_AM_USER, vme_address_space[0],
                    ctl[`PTVD_SUPER_BIT], 1'b0};
            end
            default: begin
                vme_am = 6'h00;
            end
        endcase
    end

endmodule : ptvd_image

// file: tb/ptvd_vme_slave.sv
// VMEbus slave stand-in at the far side of the target image decoder.
// Assumes vme_req is a one-cycle pulse with the attributes beside it.
`timescale 1ns/1ps

module ptvd_vme_slave (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic vme_req,
    input wire logic [31:0] vme_addr,
    output logic [15:0] hit_count,
    output logic [31:0] last_addr
);
    // ----------------------------------------
    // Cycle capture
    // ----------------------------------------
    // Accepts every cycle at once; the decoder never waits on the slave
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hit_count <= 16'h0000;
            last_addr <= 32'h0000_0000;
        end else if (vme_req) begin
            hit_count <= hit_count + 16'h0001;
            last_addr <= vme_addr;
        end
    end
endmodule : ptvd_vme_slave

// file: tb/pci_to_vme_target_image_decode_tb_top.sv
// Self-checking bench for the PCI-to-VMEbus target image decoder.
// Assumes the register port and PCI request timing of ptvd_top.
`timescale 1ns/1ps
`include "ptvd_regs.svh"

module pci_to_vme_target_image_decode_tb_top;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic pci_req = 1'b0;
    logic [31:0] pci_addr = 32'h0000_0000;
    logic pci_io = 1'b0;
    logic pci_write = 1'b0;
    logic vme_req, vme_image, vme_blt, vme_mblt, vme_posted, pci_miss;
    logic [31:0] vme_addr;
    logic [5:0] vme_am;
    logic [1:0] vme_width;
    logic [2:0] vme_space;
    logic [15:0] hit_count;
    logic [31:0] last_addr;
    int num_errors = 0;
    int total_checks = 0;
    int exp_hits = 0;
    logic [11:0] win_ofs [6] = '{`PTVD_OFS_BS6, `PTVD_OFS_BD6, `PTVD_OFS_TO6,
        `PTVD_OFS_BS7, `PTVD_OFS_BD7, `PTVD_OFS_TO7};

    always #12.5 ref_clk = ~ref_clk;

    ptvd_top u_ptvd_top (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_req(pci_req),
        .pci_addr(pci_addr), .pci_io(pci_io), .pci_write(pci_write),
        .vme_req(vme_req), .vme_image(vme_image), .vme_addr(vme_addr),
        .vme_am(vme_am), .vme_width(vme_width), .vme_space(vme_space),
        .vme_blt(vme_blt), .vme_mblt(vme_mblt), .vme_posted(vme_posted),
        .pci_miss(pci_miss));

    ptvd_vme_slave u_ptvd_vme_slave (.ref_clk(ref_clk), .reset_n(reset_n),
        .vme_req(vme_req), .vme_addr(vme_addr), .hit_count(hit_count),
        .last_addr(last_addr));

    // ----------------------------------------
    // Checking and access tasks
    // ----------------------------------------
    task stop_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd

    task pci(input logic [31:0] a, input logic io, input logic w,
             input logic hit, input logic [31:0] va);
        @(posedge ref_clk);
        pci_req <= 1'b1;
        pci_addr <= a;
        pci_io <= io;
        pci_write <= w;
        @(posedge ref_clk);
        pci_req <= 1'b0;
        #1;
        chk(32'(vme_req), 32'(hit));
        chk(32'(pci_miss), 32'(!hit));
        if (hit) begin
            chk(vme_addr, va);
            exp_hits++;
        end
    endtask : pci

    function automatic logic [31:0] ctl(input logic en, input logic pw,
        input logic [1:0] w, input logic [2:0] s, input logic pg,
        input logic su, input logic block_transfer_select, input logic pci_space_select);
        ctl = {en, pw, 6'h00, w, 3'h0, s, 1'b0, pg, 1'b0, su, 3'h0, block_transfer_select,
            7'h00, pci_space_select};
    endfunction : ctl

    function automatic logic [5:0] am(input logic [2:0] s, input logic su,
        input logic pg, input logic blt, input logic mblt);
        logic [1:0] lo;
        lo = mblt ? 2'b00 : (blt ? 2'b11 : (pg ? 2'b10 : 2'b01));
        case (s)
            3'd1: am = {3'b111, su, lo};
            3'd2: am = {3'b001, su, lo};
            3'd5: am = 6'h2f;
            3'd6, 3'd7: am = {3'b010, s[0], su, 1'b0};
            default: am = {3'b101, su, 2'b01};
        endcase
    endfunction : am

    // Hang guard far beyond the length of the sequence
    initial begin
        #500000;
        num_errors++;
        stop_test();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        logic a2432, blt, mblt, hit;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(`PTVD_OFS_CTL6, `PTVD_CTL_RST);
        rd(`PTVD_OFS_CTL7, `PTVD_CTL_RST);
        for (int i = 0; i < 6; i++) begin
            rd(win_ofs[i], `PTVD_WIN_RST);
            wr(win_ofs[i], 32'hffff_ffff);
            rd(win_ofs[i], `PTVD_WIN_MASK);
            wr(win_ofs[i], 32'h0000_0000);
        end
        wr(`PTVD_OFS_CTL6, 32'hffff_ffff);
        rd(`PTVD_OFS_CTL6, `PTVD_CTL_MASK);
        wr(`PTVD_OFS_CTL6, 32'h0000_0000);
        wr(12'h1f4, 32'hffff_ffff);
        rd(12'h1f4, 32'h0000_0000);
        $display("test registers done");

        wr(`PTVD_OFS_BS6, 32'h1000_0000);
        wr(`PTVD_OFS_BD6, 32'h2000_0000);
        pci(32'h1000_0000, 1'b0, 1'b0, 1'b0, 32'h0);
        wr(`PTVD_OFS_CTL6, ctl(1, 0, 2'd2, 3'd2, 0, 0, 0, 0));
        pci(32'h1000_0000, 1'b0, 1'b0, 1'b1, 32'h1000_0000);
        pci(32'h1fff_ffff, 1'b0, 1'b0, 1'b1, 32'h1fff_ffff);
        pci(32'h2000_0000, 1'b0, 1'b0, 1'b0, 32'h0);
        pci(32'h0fff_ffff, 1'b0, 1'b0, 1'b0, 32'h0);
        wr(`PTVD_OFS_TO6, 32'h3000_0000);
        pci(32'h1234_5678, 1'b0, 1'b0, 1'b1, 32'h4234_5678);
        wr(`PTVD_OFS_TO6, 32'hf000_0000);
        pci(32'h1234_5678, 1'b0, 1'b0, 1'b1, 32'h0234_5678);
        $display("test window done");

        wr(`PTVD_OFS_BS7, 32'hf000_0000);
        wr(`PTVD_OFS_CTL7, ctl(1, 0, 2'd2, 3'd2, 0, 0, 0, 0));
        pci(32'hffff_fffc, 1'b0, 1'b0, 1'b1, 32'hffff_fffc);
        chk(32'(vme_image), 32'h1);
        pci(32'hefff_ffff, 1'b0, 1'b0, 1'b0, 32'h0);
        pci(32'h1000_0004, 1'b0, 1'b0, 1'b1, 32'h0000_0004);
        chk(32'(vme_image), 32'h0);
        wr(`PTVD_OFS_BD6, 32'h0000_0000);
        pci(32'hffff_fffc, 1'b0, 1'b0, 1'b1, 32'hefff_fffc);
        chk(32'(vme_image), 32'h0);
        wr(`PTVD_OFS_CTL7, 32'h0000_0000);
        wr(`PTVD_OFS_TO6, 32'h0000_0000);
        $display("test bound zero done");

        for (int w = 0; w < 4; w++) begin
            for (int s = 0; s < 8; s++) begin
                a2432 = (s == 1) || (s == 2);
                blt = a2432 && (w != 3) && (w[0] ^ s[0]);
                mblt = a2432 && (w == 3);
                hit = (s != 3) && (s != 4);
                wr(`PTVD_OFS_CTL6, ctl(1, 0, w[1:0], s[2:0], s[0], w[0],
                    w[0] ^ s[0], 0));
                pci(32'h1000_0010, 1'b0, 1'b0, hit, 32'h1000_0010);
                if (hit) begin
                    chk(32'(vme_width), 32'(w));
                    chk(32'(vme_space), 32'(s));
                    chk(32'(vme_blt), 32'(blt));
                    chk(32'(vme_mblt), 32'(mblt));
                    chk(32'(vme_am), 32'(am(s[2:0], w[0], s[0], blt,
                        mblt)));
                end
            end
        end
        $display("test attributes done");

        wr(`PTVD_OFS_CTL6, ctl(1, 1, 2'd2, 3'd2, 0, 0, 0, 1));
        pci(32'h1000_0020, 1'b0, 1'b1, 1'b0, 32'h0);
        pci(32'h1000_0020, 1'b1, 1'b1, 1'b1, 32'h1000_0020);
        chk(32'(vme_posted), 32'h0);
        wr(`PTVD_OFS_CTL6, ctl(1, 1, 2'd2, 3'd2, 0, 0, 0, 0));
        pci(32'h1000_0020, 1'b1, 1'b1, 1'b0, 32'h0);
        pci(32'h1000_0020, 1'b0, 1'b1, 1'b1, 32'h1000_0020);
        chk(32'(vme_posted), 32'h1);
        pci(32'h1000_0024, 1'b0, 1'b0, 1'b1, 32'h1000_0024);
        chk(32'(vme_posted), 32'h0);
        wr(`PTVD_OFS_CTL6, ctl(1, 0, 2'd2, 3'd2, 0, 0, 0, 0));
        pci(32'h1000_0028, 1'b0, 1'b1, 1'b1, 32'h1000_0028);
        chk(32'(vme_posted), 32'h0);
        $display("test posting done");

        @(posedge ref_clk);
        #1;
        chk(32'(hit_count), 32'(exp_hits));
        chk(last_addr, 32'h1000_0028);
        rd(`PTVD_OFS_STAT, 32'h0000_0007);
        wr(`PTVD_OFS_STAT, 32'h0000_0005);
        rd(`PTVD_OFS_STAT, 32'h0000_0002);
        $display("test status done");
        stop_test();
    end
endmodule : pci_to_vme_target_image_decode_tb_top
